//--- rtl/ledbl_pkg.sv
// constants, encodings and timing counts for the backlight power controller
// assumes a single 250 MHz clock and an I2C host on the two serial pins
`default_nettype none

package ledbl_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SETTLE_US = 100;
  localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int unsigned RST_FILT_US = 50;
  localparam int unsigned RST_FILT_CYC = RST_FILT_US * CLK_MHZ;
  localparam int unsigned FS_CODE = 127;
  // fade unit: one tenth of a second spread over the full code span
  localparam int unsigned FADE_BASE_MS = 100;
  localparam int unsigned FADE_UNIT_CYC = FADE_BASE_MS * 1000 * CLK_MHZ / FS_CODE;
  localparam int unsigned PUMP_DIV_CYC = 250;
  localparam int unsigned NUM_SINKS = 7;
  localparam int unsigned CNT_W = 20;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h01;
  localparam logic [7:0] REG_LAW = 8'h04;
  localparam logic [7:0] REG_SINK_EN = 8'h05;
  localparam logic [7:0] REG_MAX = 8'h09;
  localparam logic [7:0] REG_DIM = 8'h0a;
  localparam logic [7:0] REG_FADE = 8'h0c;

  localparam int unsigned MODE_BLON_BIT = 0;
  localparam int unsigned MODE_DIM_BIT = 1;
  localparam int unsigned MODE_RUN_BIT = 5;
  localparam int unsigned LAW_LSB = 0;
  localparam int unsigned FADE_IN_LSB = 0;
  localparam int unsigned FADE_OUT_LSB = 4;

  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] LAW_RST = 8'h00;
  localparam logic [7:0] SINK_EN_RST = 8'h7f;
  localparam logic [7:0] MAX_RST = 8'h00;
  localparam logic [7:0] DIM_RST = 8'h00;
  localparam logic [7:0] FADE_RST = 8'h00;

  localparam logic [1:0] LAW_LINEAR = 2'h0;
  localparam logic [1:0] LAW_SQUARE = 2'h1;
  localparam logic [1:0] LAW_CUBIC10 = 2'h2;
  localparam logic [1:0] LAW_CUBIC11 = 2'h3;

  localparam logic [6:0] CUBE_KNEE_LO = 7'h20;
  localparam logic [6:0] CUBE_KNEE_HI = 7'h40;

  localparam logic [6:0] I2C_DEV_ADDR = 7'h2a;

  // ****************************************
  // state encodings
  // ****************************************
  typedef enum logic [1:0] {MD_SHUTDOWN, MD_STANDBY, MD_SOFTSTART, MD_ACTIVE} ledbl_mode_t;
  typedef enum logic [1:0] {G_1X, G_1P5X, G_2X} ledbl_gain_t;
  typedef enum logic [3:0] {I_IDLE, I_ADDR, I_AACK, I_PTR, I_PACK, I_WDAT, I_WACK, I_RDAT, I_RACK} ledbl_i2c_t;

  // fade rate code to tenths of a second per full scale
  function automatic logic [7:0] ledbl_rate_tenths(input logic [3:0] code);
    if (code == 4'h0) begin
      return 8'h01;
    end else if (code <= 4'ha) begin
      return 8'({4'h0, code} * 8'h03);
    end else begin
      return 8'(8'h1e + ({4'h0, code} - 8'h0a) * 8'h05);
    end
  endfunction : ledbl_rate_tenths

endpackage : ledbl_pkg

`default_nettype wire

//--- rtl/ledbl_ctrl.sv
// backlight power controller: i2c register slave, mode machine, pump gain
// stepping and level fading
// assumes analog comparators and pins arrive asynchronously; all are synced here
`default_nettype none

// How it works
// - pump gain is one of 1x, 1.5x, 2x, chosen automatically
// - boosted gains alternate charge and discharge; series for 1.5x, parallel 2x
// - on fault all pump switches open, isolating output from input
// - any enabled sink below headroom steps gain up, starting at 1x
// - after each gain change wait 100 us before deciding again
// - still short of headroom at 1.5x steps on to 2x
// - all enabled sinks above the down threshold step gain down
// - disabled sinks are ignored in every gain decision
// - every start runs soft start until output near input, then 1x
// - run request bit at 1 enters active mode
// - run request at 0 or reset pin held low gives standby
// - leaving standby always runs the full soft start first
// - supply rising above start level resets registers and enters standby
// - while reset pin low: standby, default registers, no i2c acknowledge
// - after reset pin release stay in standby, accept i2c again
// - reset pin must stay low through the 50 us filter
// - maximum and dim levels are 7-bit codes at backlight_max_level and backlight_dim_level
// - law 00 is linear, code times full scale over 127
// - law 01 is square of code scaled by full scale over 127 squared
// - sixteen fade rates from 0.1 to 5.5 s per full scale
// - rate code table: 0 is 0.1 s, then 0.3 s steps, then 0.5 s steps
// - fade time is rate times code change over 127
// - cubic laws use square currents with step interval varied by level
module ledbl_ctrl
  import ledbl_pkg::*;
#(
  parameter int unsigned NS = NUM_SINKS,
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned RST_FILT_CYCLES = RST_FILT_CYC,
  parameter int unsigned FADE_UNIT_CYCLES = FADE_UNIT_CYC,
  parameter int unsigned PUMP_DIV_CYCLES = PUMP_DIV_CYC,
  parameter logic [6:0] DEV_ADDR = I2C_DEV_ADDR
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic hw_reset_pin_n_i,
  input wire logic supply_ok_i,
  input wire logic vout_ready_i,
  input wire logic fault_i,
  input wire logic [NS-1:0] sink_low_i,
  input wire logic [NS-1:0] sink_high_i,
  output logic [1:0] gain_o,
  output logic pass_through_o,
  output logic pump_charge_o,
  output logic caps_series_o,
  output logic isolate_o,
  output logic softstart_current_o,
  output logic standby_o,
  output logic [6:0] bl_code_o,
  output logic [13:0] bl_current_o
);

  // ****************************************
  // state
  // ****************************************
  localparam int unsigned SW = 6 + 2 * NS;

  typedef struct packed {
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic scl_p;
    logic sda_p;
    logic [CNT_W-1:0] rst_cnt;
    logic rst_act;
    ledbl_mode_t mode;
    ledbl_gain_t gain;
    logic [CNT_W-1:0] settle;
    logic [CNT_W-1:0] div;
    logic phase;
    logic [7:0] r_mode;
    logic [7:0] r_law;
    logic [7:0] r_sink;
    logic [7:0] r_max;
    logic [7:0] r_dim;
    logic [7:0] r_fade;
    ledbl_i2c_t ist;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic nack;
    logic [6:0] cur;
    logic [CNT_W-1:0] unit_cnt;
    logic [7:0] step_cnt;
    logic pass;
    logic pump_charge;
    logic caps_series;
    logic isolate;
    logic ss_en;
    logic standby;
    logic [13:0] bl_cur;
    logic sda_lo;
    logic sda_oe;
  } ledbl_state_t;

  ledbl_state_t q;
  ledbl_state_t d;

  logic scl_s;
  logic sda_s;
  logic rstpin_s;
  logic supply_s;
  logic vout_s;
  logic fault_s;
  logic [NS-1:0] lo_v;
  logic [NS-1:0] hi_v;
  logic [NS-1:0] en_v;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic clr_regs;
  logic ack_ok;
  logic boost;
  logic act;
  logic unit_tick;
  logic [7:0] rdat;
  logic [7:0] rate;
  logic [7:0] units;
  logic [1:0] mult;
  logic [6:0] tgt;
  logic [1:0] law;

  always_comb begin
    d = q;
    scl_s = q.sync2[0];
    sda_s = q.sync2[1];
    rstpin_s = q.sync2[2];
    supply_s = q.sync2[3];
    vout_s = q.sync2[4];
    fault_s = q.sync2[5];
    lo_v = q.sync2[6 +: NS];
    hi_v = q.sync2[6 + NS +: NS];
    en_v = q.r_sink[NS-1:0];
    rise = scl_s & ~q.scl_p;
    fall = ~scl_s & q.scl_p;
    start = scl_s & q.scl_p & q.sda_p & ~sda_s;
    stop = scl_s & q.scl_p & ~q.sda_p & sda_s;
    ack_ok = ~q.rst_act & (q.mode != MD_SHUTDOWN);
    clr_regs = 1'b0;
    boost = 1'b0;
    act = 1'b0;
    unit_tick = 1'b0;
    rate = 8'h00;
    units = 8'h00;
    mult = 2'h1;
    tgt = 7'h00;
    law = q.r_law[LAW_LSB +: 2];

    // ****************************************
    // input synchronisers
    // ****************************************
    d.sync1 = {sink_high_i, sink_low_i, fault_i, vout_ready_i, supply_ok_i, hw_reset_pin_n_i, sda_i, scl_i};
    d.sync2 = q.sync1;
    d.scl_p = scl_s;
    d.sda_p = sda_s;

    // ****************************************
    // reset pin filter
    // ****************************************
    // low for whole interval
    if (rstpin_s) begin
      d.rst_cnt = '0;
      d.rst_act = 1'b0;
    end else if (q.rst_cnt == CNT_W'(RST_FILT_CYCLES - 1)) begin
      d.rst_act = 1'b1;
    end else begin
      d.rst_cnt = q.rst_cnt + CNT_W'(1);
    end

    // ****************************************
    // read data decode
    // ****************************************
    case (q.ptr)
      REG_STATUS: rdat = {2'h0, q.mode, 2'h0, q.gain};
      REG_MODE: rdat = q.r_mode;
      REG_LAW: rdat = q.r_law;
      REG_SINK_EN: rdat = q.r_sink;
      REG_MAX: rdat = q.r_max;
      REG_DIM: rdat = q.r_dim;
      REG_FADE: rdat = q.r_fade;
      default: rdat = 8'h00;
    endcase

    // ****************************************
    // i2c slave
    // ****************************************
    if (start) begin
      d.ist = I_ADDR;
      d.bcnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop) begin
      d.ist = I_IDLE;
      d.sda_oe = 1'b0;
    end else if (rise) begin
      case (q.ist)
        I_ADDR, I_PTR, I_WDAT: begin
          d.sh = {q.sh[6:0], sda_s};
          d.bcnt = q.bcnt + 4'h1;
        end
        I_RACK: d.nack = sda_s;
        default: ;
      endcase
    end else if (fall) begin
      case (q.ist)
        I_ADDR: begin
          if (q.bcnt == 4'h8) begin
            if (q.sh[7:1] == DEV_ADDR && ack_ok) begin
              d.sda_oe = 1'b1;
              d.rw = q.sh[0];
              d.ist = I_AACK;
            end else begin
              d.ist = I_IDLE;
            end
          end
        end
        I_AACK: begin
          if (q.rw) begin
            d.sh = rdat;
            d.sda_oe = ~rdat[7];
            d.bcnt = 4'h1;
            d.ist = I_RDAT;
          end else begin
            d.sda_oe = 1'b0;
            d.bcnt = 4'h0;
            d.ist = I_PTR;
          end
        end
        I_PTR: begin
          if (q.bcnt == 4'h8) begin
            d.ptr = q.sh;
            d.sda_oe = 1'b1;
            d.ist = I_PACK;
          end
        end
        I_PACK, I_WACK: begin
          d.sda_oe = 1'b0;
          d.bcnt = 4'h0;
          d.ist = I_WDAT;
        end
        I_WDAT: begin
          if (q.bcnt == 4'h8) begin
            // new codes used from next step
            case (q.ptr)
              REG_MODE: d.r_mode = q.sh;
              REG_LAW: d.r_law = q.sh;
              REG_SINK_EN: d.r_sink = q.sh;
              REG_MAX: d.r_max = q.sh;
              REG_DIM: d.r_dim = q.sh;
              REG_FADE: d.r_fade = q.sh;
              default: ;
            endcase
            d.ptr = q.ptr + 8'h01;
            d.sda_oe = 1'b1;
            d.ist = I_WACK;
          end
        end
        I_RDAT: begin
          if (q.bcnt == 4'h8) begin
            d.sda_oe = 1'b0;
            d.ptr = q.ptr + 8'h01;
            d.ist = I_RACK;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
            d.bcnt = q.bcnt + 4'h1;
          end
        end
        I_RACK: begin
          if (q.nack) begin
            d.ist = I_IDLE;
          end else begin
            d.sh = rdat;
            d.sda_oe = ~rdat[7];
            d.bcnt = 4'h1;
            d.ist = I_RDAT;
          end
        end
        default: d.ist = I_IDLE;
      endcase
    end

    // ****************************************
    // operating mode
    // ****************************************
    case (q.mode)
      MD_SHUTDOWN: begin
        if (supply_s) begin
          d.mode = MD_STANDBY;
        end
      end
      MD_STANDBY: begin
        if (q.r_mode[MODE_RUN_BIT]) begin
          d.mode = MD_SOFTSTART;
        end
      end
      MD_SOFTSTART: begin
        if (!q.r_mode[MODE_RUN_BIT]) begin
          d.mode = MD_STANDBY;
        end else if (vout_s) begin
          d.mode = MD_ACTIVE;
          d.gain = G_1X;
          d.settle = '0;
        end
      end
      MD_ACTIVE: begin
        if (!q.r_mode[MODE_RUN_BIT]) begin
          d.mode = MD_STANDBY;
        end
      end
      default: d.mode = MD_SHUTDOWN;
    endcase
    // a fault drops the run request so the host restarts with a fresh soft start
    if (fault_s && (q.mode == MD_ACTIVE || q.mode == MD_SOFTSTART)) begin
      d.mode = MD_STANDBY;
      d.r_mode[MODE_RUN_BIT] = 1'b0;
    end
    if (q.rst_act) begin
      d.mode = MD_STANDBY;
      d.ist = I_IDLE;
      d.sda_oe = 1'b0;
      clr_regs = 1'b1;
    end
    if (!supply_s) begin
      d.mode = MD_SHUTDOWN;
      d.ist = I_IDLE;
      d.sda_oe = 1'b0;
      clr_regs = 1'b1;
    end
    if (clr_regs) begin
      d.r_mode = MODE_RST;
      d.r_law = LAW_RST;
      d.r_sink = SINK_EN_RST;
      d.r_max = MAX_RST;
      d.r_dim = DIM_RST;
      d.r_fade = FADE_RST;
    end

    // ****************************************
    // automatic gain selection
    // ****************************************
    // settle counted in clock ticks
    if (d.mode != MD_ACTIVE) begin
      d.gain = G_1X;
      d.settle = '0;
    end else if (q.mode == MD_ACTIVE) begin
      if (q.settle != '0) begin
        d.settle = q.settle - CNT_W'(1);
      end else if (|(lo_v & en_v) && q.gain != G_2X) begin
        d.gain = (q.gain == G_1X) ? G_1P5X : G_2X;
        d.settle = CNT_W'(SETTLE_CYCLES - 1);
      end else if (&(hi_v | ~en_v) && |en_v && q.gain != G_1X) begin
        d.gain = (q.gain == G_2X) ? G_1P5X : G_1X;
        d.settle = CNT_W'(SETTLE_CYCLES - 1);
      end
    end

    // ****************************************
    // pump switch phases
    // ****************************************
    act = (d.mode == MD_ACTIVE);
    boost = act && (d.gain != G_1X);
    if (boost) begin
      if (q.div == CNT_W'(PUMP_DIV_CYCLES - 1)) begin
        d.div = '0;
        d.phase = ~q.phase;
      end else begin
        d.div = q.div + CNT_W'(1);
      end
    end else begin
      d.div = '0;
      d.phase = 1'b0;
    end
    d.pass = act && (d.gain == G_1X) && !fault_s;
    d.pump_charge = boost && d.phase && !fault_s;
    d.caps_series = boost && d.phase && (d.gain == G_1P5X) && !fault_s;
    d.isolate = !act || fault_s;
    d.ss_en = (d.mode == MD_SOFTSTART);
    d.standby = (d.mode == MD_STANDBY) || (d.mode == MD_SHUTDOWN);

    // ****************************************
    // level selection and fade
    // ****************************************
    // seven-bit max or dim code
    if (q.r_mode[MODE_BLON_BIT]) begin
      tgt = q.r_mode[MODE_DIM_BIT] ? q.r_dim[6:0] : q.r_max[6:0];
    end
    rate = ledbl_rate_tenths((q.cur < tgt) ? q.r_fade[FADE_IN_LSB +: 4] : q.r_fade[FADE_OUT_LSB +: 4]);
    if (law == LAW_CUBIC10) begin
      mult = (q.cur < CUBE_KNEE_HI) ? 2'h2 : 2'h1;
    end else if (law == LAW_CUBIC11) begin
      mult = (q.cur < CUBE_KNEE_LO) ? 2'h3 : ((q.cur < CUBE_KNEE_HI) ? 2'h2 : 2'h1);
    end
    units = 8'(rate * {6'h00, mult});
    if (!act) begin
      d.cur = 7'h00;
      d.unit_cnt = '0;
      d.step_cnt = 8'h00;
    end else if (q.cur == tgt) begin
      d.unit_cnt = '0;
      d.step_cnt = 8'h00;
    end else begin
      if (q.unit_cnt == CNT_W'(FADE_UNIT_CYCLES - 1)) begin
        d.unit_cnt = '0;
        unit_tick = 1'b1;
      end else begin
        d.unit_cnt = q.unit_cnt + CNT_W'(1);
      end
      if (unit_tick) begin
        if (q.step_cnt + 8'h01 >= units) begin
          d.step_cnt = 8'h00;
          d.cur = (q.cur < tgt) ? q.cur + 7'h01 : q.cur - 7'h01;
        end else begin
          d.step_cnt = q.step_cnt + 8'h01;
        end
      end
    end
    if (!act) begin
      d.bl_cur = 14'h0000;
    end else if (law == LAW_LINEAR) begin
      d.bl_cur = 14'({7'h00, d.cur} * 14'd127);
    end else begin
      d.bl_cur = 14'({7'h00, d.cur} * {7'h00, d.cur});
    end
    d.sda_lo = 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      q <= '{sync1: SW'(3'h7), sync2: SW'(3'h7), scl_p: 1'b1, sda_p: 1'b1, rst_cnt: '0, rst_act: 1'b0,
             mode: MD_SHUTDOWN, gain: G_1X, settle: '0, div: '0, phase: 1'b0,
             r_mode: MODE_RST, r_law: LAW_RST, r_sink: SINK_EN_RST, r_max: MAX_RST,
             r_dim: DIM_RST, r_fade: FADE_RST, ist: I_IDLE, bcnt: 4'h0, sh: 8'h00,
             ptr: 8'h00, rw: 1'b0, nack: 1'b0, cur: 7'h00, unit_cnt: '0, step_cnt: 8'h00,
             pass: 1'b0, pump_charge: 1'b0, caps_series: 1'b0, isolate: 1'b1, ss_en: 1'b0,
             standby: 1'b1, bl_cur: 14'h0000, sda_lo: 1'b0, sda_oe: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign sda_o = q.sda_lo;
  assign sda_oe_o = q.sda_oe;
  assign gain_o = q.gain;
  assign pass_through_o = q.pass;
  assign pump_charge_o = q.pump_charge;
  assign caps_series_o = q.caps_series;
  assign isolate_o = q.isolate;
  assign softstart_current_o = q.ss_en;
  assign standby_o = q.standby;
  assign bl_code_o = q.cur;
  assign bl_current_o = q.bl_cur;

endmodule : ledbl_ctrl

`default_nettype wire

//--- verification/ledbl_ctrl_sva.sv
// checker for the backlight power controller, bound to its ports
// assumes one clock domain with a synchronous active-low reset
`default_nettype none
module ledbl_ctrl_sva
  import ledbl_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned RST_FILT_CYCLES = RST_FILT_CYC,
  parameter int unsigned PUMP_DIV_CYCLES = PUMP_DIV_CYC
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic sda_oe_o,
  input wire logic hw_reset_pin_n_i,
  input wire logic fault_i,
  input wire logic [1:0] gain_o,
  input wire logic pass_through_o,
  input wire logic pump_charge_o,
  input wire logic caps_series_o,
  input wire logic isolate_o,
  input wire logic softstart_current_o,
  input wire logic standby_o,
  input wire logic [6:0] bl_code_o
);
  typedef struct packed {
    logic [1:0] gain;
    logic pc;
    logic [15:0] since;
    logic [15:0] still;
    logic [15:0] low;
  } ledbl_sva_t;
  ledbl_sva_t s_q, s_d;
  logic g_chg;
  assign g_chg = gain_o != s_q.gain;
  always_comb begin
    s_d = s_q;
    s_d.gain = gain_o;
    s_d.pc = pump_charge_o;
    // saturate so a long quiet spell never wraps into a false short gap
    s_d.since = isolate_o ? 16'hffff : g_chg ? 16'h0 : s_q.since + 16'(s_q.since != 16'hffff);
    s_d.still = (pump_charge_o == s_q.pc && gain_o != G_1X && !isolate_o) ? s_q.still + 16'h1 : 16'h0;
    s_d.low = hw_reset_pin_n_i ? 16'h0 : s_q.low + 16'(s_q.low != 16'hffff);
  end
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s_q <= '{gain: 2'h0, pc: 1'b0, since: 16'hffff, still: 16'h0, low: 16'h0};
    end else begin
      s_q <= s_d;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  AST_GAIN_CODE: assert property (gain_o != 2'h3)
    else $error("gain code out of range");
  AST_GAIN_STEP: assert property (g_chg && !isolate_o && !$past(isolate_o) |->
    gain_o - s_q.gain == 2'h1 || s_q.gain - gain_o == 2'h1)
    else $error("gain moved more than one step");
  AST_SETTLE: assert property (g_chg && !isolate_o && !$past(isolate_o) |-> s_q.since >= SETTLE_CYCLES - 1)
    else $error("gain changed before settle time");
  AST_CAPS_SERIES: assert property (!isolate_o |-> caps_series_o == (pump_charge_o && gain_o == G_1P5X))
    else $error("capacitor series control wrong");
  AST_PUMP_TOGGLE: assert property (s_q.still <= PUMP_DIV_CYCLES + 1)
    else $error("boosted pump stopped alternating");
  AST_ISOLATED: assert property (isolate_o |-> !pump_charge_o && !pass_through_o)
    else $error("switch closed while isolated");
  AST_FAULT_ISOLATE: assert property (fault_i [*5] |-> isolate_o)
    else $error("fault did not isolate");
  AST_PASS_1X: assert property (pass_through_o |-> gain_o == G_1X && !standby_o)
    else $error("pass through outside active 1x");
  AST_SOFTSTART: assert property (softstart_current_o |-> !pass_through_o && !pump_charge_o && !standby_o)
    else $error("soft start overlaps pump operation");
  AST_PIN_RESET: assert property (s_q.low > RST_FILT_CYCLES + 6 |-> standby_o && !sda_oe_o)
    else $error("pin reset not holding standby");
  AST_CODE_STEP: assert property ($changed(bl_code_o) && !isolate_o && !$past(isolate_o) |->
    bl_code_o == $past(bl_code_o) + 7'h1 || bl_code_o + 7'h1 == $past(bl_code_o))
    else $error("level code jumped");
  cover property (gain_o == G_2X && pump_charge_o);
  cover property (caps_series_o);
  cover property (s_q.low > RST_FILT_CYCLES + 6);
endmodule : ledbl_ctrl_sva

bind ledbl_ctrl ledbl_ctrl_sva #(.SETTLE_CYCLES(SETTLE_CYCLES), .RST_FILT_CYCLES(RST_FILT_CYCLES),
  .PUMP_DIV_CYCLES(PUMP_DIV_CYCLES)) u_sva (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .sda_oe_o(sda_oe_o),
  .hw_reset_pin_n_i(hw_reset_pin_n_i), .fault_i(fault_i), .gain_o(gain_o), .pass_through_o(pass_through_o),
  .pump_charge_o(pump_charge_o), .caps_series_o(caps_series_o), .isolate_o(isolate_o),
  .softstart_current_o(softstart_current_o), .standby_o(standby_o), .bl_code_o(bl_code_o));
`default_nettype wire

//--- verification/ledbl_i2c_host.sv
// i2c host model for the controller's serial pins
// assumes the bench resolves the open-drain wire and returns it on sda_w_i
`default_nettype none
module ledbl_i2c_host
  import ledbl_pkg::*;
#(
  parameter int HALF = 10
) (
  input wire logic clk_i,
  input wire logic sda_w_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hold(input int k);
    repeat (k) @(posedge clk_i);
  endtask : hold
  // also serves as repeated start, entered with scl low
  task automatic start();
    sda_o <= 1'b1;
    hold(HALF);
    scl_o <= 1'b1;
    hold(HALF);
    sda_o <= 1'b0;
    hold(HALF);
    scl_o <= 1'b0;
  endtask : start
  task automatic stop();
    hold(2);
    sda_o <= 1'b0;
    hold(HALF);
    scl_o <= 1'b1;
    hold(HALF);
    sda_o <= 1'b1;
    hold(HALF);
  endtask : stop
  // nine bits, a 1 releases the line; wire level sampled mid high phase
  task automatic byte9(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      hold(2);
      sda_o <= v[i];
      hold(HALF);
      scl_o <= 1'b1;
      hold(HALF / 2);
      r[i] = sda_w_i;
      hold(HALF / 2);
      scl_o <= 1'b0;
    end
  endtask : byte9
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ack);
    logic [8:0] a, b, c;
    start();
    byte9({I2C_DEV_ADDR, 2'h1}, a);
    byte9({p, 1'b1}, b);
    byte9({d, 1'b1}, c);
    stop();
    ack = !a[0] && !b[0] && !c[0];
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ack);
    logic [8:0] a, b, c, e;
    start();
    byte9({I2C_DEV_ADDR, 2'h1}, a);
    byte9({p, 1'b1}, b);
    start();
    byte9({I2C_DEV_ADDR, 2'h3}, c);
    byte9(9'h1ff, e);
    stop();
    d = e[8:1];
    ack = !a[0] && !b[0] && !c[0];
  endtask : rd
endmodule : ledbl_i2c_host
`default_nettype wire

//--- verification/ledbl_ctrl_tb_top.sv
// self-checking bench for the backlight power controller
// assumes the host model ledbl_i2c_host and shortened timing parameters
`default_nettype none
module ledbl_ctrl_tb_top
  import ledbl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 20;
  localparam int FU = 4;
  logic clk, resetn, scl, h_sda, sda_w, sda_o, sda_oe, pin_n, sup_ok, vrdy, fault, pass, chg, ser, iso, ssc, stby, ack;
  logic [6:0] lo, hi, code;
  logic [1:0] gain;
  logic [13:0] cur;
  logic [7:0] rv, lvl, dim;
  logic [31:0] xs_q;
  int fail_count, checks, n;
  assign sda_w = h_sda & ~(sda_oe & ~sda_o);
  ledbl_ctrl #(.SETTLE_CYCLES(ST), .RST_FILT_CYCLES(10), .FADE_UNIT_CYCLES(FU), .PUMP_DIV_CYCLES(2)) uut (
    .sys_clk_i(clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .hw_reset_pin_n_i(pin_n), .supply_ok_i(sup_ok), .vout_ready_i(vrdy), .fault_i(fault), .sink_low_i(lo),
    .sink_high_i(hi), .gain_o(gain), .pass_through_o(pass), .pump_charge_o(chg), .caps_series_o(ser),
    .isolate_o(iso), .softstart_current_o(ssc), .standby_o(stby), .bl_code_o(code), .bl_current_o(cur));
  ledbl_i2c_host host (.clk_i(clk), .sda_w_i(sda_w), .scl_o(scl), .sda_o(h_sda));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    xs_q ^= xs_q << 13;
    xs_q ^= xs_q >> 17;
    xs_q ^= xs_q << 5;
    return xs_q;
  endfunction : xs
  // cycles between fade steps for a rate code, law and level
  function automatic int gap(input int rate, input int law, input int c);
    int t;
    t = rate == 0 ? 1 : rate <= 10 ? 3 * rate : 30 + 5 * (rate - 10);
    if (law == 2 && c < 64) t *= 2;
    if (law == 3) t *= c < 32 ? 3 : c < 64 ? 2 : 1;
    return t * FU;
  endfunction : gap
  function automatic logic [15:0] amps(input int law, input int c);
    return law == 0 ? 16'(c * 127) : 16'(c * c);
  endfunction : amps
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_gain(input logic [1:0] g);
    n = 0;
    while (gain !== g && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_gain
  task automatic wait_code(input logic [6:0] c);
    n = 0;
    while (code !== c && n < 3000) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_code
  // time one whole fade step
  task automatic step_gap(input logic up);
    for (int k = 0; k < 2; k++) wait_code(up ? code + 7'h1 : code - 7'h1);
  endtask : step_gap
  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("mismatch watchdog expected end seen timeout");
    results();
  end
  initial begin
    {resetn, vrdy, fault, lo, hi} = '0;
    {pin_n, sup_ok} = 2'h3;
    xs_q = 32'h2;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    chk("standby", 1, stby);
    chk("isolate", 1, iso);
    for (int j = 0; j < 4; j++) begin
      host.wr(REG_LAW, 8'(j), ack);
      host.rd(REG_LAW, rv, ack);
      chk("law", 16'(j), {8'h0, rv});
    end
    lvl = 8'h60 + 8'(xs() % 32);
    dim = lvl / 2 - 8;
    host.wr(REG_MAX, lvl, ack);
    host.rd(REG_MAX, rv, ack);
    chk("max", lvl, rv);
    host.rd(8'h30, rv, ack);
    chk("unmapped", 0, rv);
    pin_n <= 1'b0;
    repeat (5) @(posedge clk);
    pin_n <= 1'b1;
    repeat (10) @(posedge clk);
    host.rd(REG_LAW, rv, ack);
    chk("law kept", 3, rv);
    pin_n <= 1'b0;
    repeat (30) @(posedge clk);
    host.wr(REG_DIM, dim, ack);
    chk("ack in reset", 0, ack);
    chk("standby", 1, stby);
    pin_n <= 1'b1;
    repeat (6) @(posedge clk);
    host.rd(REG_MAX, rv, ack);
    chk("max default", 0, rv);
    chk("ack", 1, ack);
    host.wr(REG_MODE, 8'h20, ack);
    repeat (4) @(posedge clk);
    chk("softstart", 1, ssc);
    chk("pass", 0, pass);
    vrdy <= 1'b1;
    repeat (8) @(posedge clk);
    chk("pass", 1, pass);
    chk("gain", G_1X, gain);
    host.wr(REG_SINK_EN, 8'h0f, ack);
    lo <= 7'h70;
    repeat (40) @(posedge clk);
    chk("gain off sinks", G_1X, gain);
    lo <= 7'(xs()) & 7'h0f | 7'h01;
    wait_gain(G_1P5X);
    chk("gain up", G_1P5X, gain);
    wait_gain(G_2X);
    chk("gain 2x", G_2X, gain);
    chk("settle", 1, 16'(n >= ST - 1 && n <= ST + 8));
    lo <= 7'h0;
    hi <= 7'h0f;
    wait_gain(G_1P5X);
    wait_gain(G_1X);
    chk("gain down", G_1X, gain);
    hi <= 7'h0;
    host.wr(REG_MAX, lvl, ack);
    host.wr(REG_DIM, dim, ack);
    host.wr(REG_MODE, 8'h21, ack);
    step_gap(1'b1);
    chk("gap rate 0", 16'(gap(0, 0, 64)), 16'(n));
    wait_code(lvl[6:0]);
    chk("max code", lvl, code);
    chk("linear", amps(0, lvl), cur);
    host.wr(REG_FADE, 8'h11, ack);
    host.wr(REG_LAW, 8'h02, ack);
    host.wr(REG_MODE, 8'h23, ack);
    step_gap(1'b0);
    chk("gap rate 1", 16'(gap(1, 2, 80)), 16'(n));
    while (code >= 7'h3c) @(posedge clk);
    step_gap(1'b0);
    chk("gap cubic low", 16'(gap(1, 2, 40)), 16'(n));
    wait_code(dim[6:0]);
    chk("dim code", dim, code);
    chk("square", amps(2, dim), cur);
    fault <= 1'b1;
    repeat (6) @(posedge clk);
    chk("fault isolate", 1, iso);
    chk("fault pass", 0, pass);
    fault <= 1'b0;
    sup_ok <= 1'b0;
    repeat (6) @(posedge clk);
    sup_ok <= 1'b1;
    repeat (8) @(posedge clk);
    chk("por standby", 1, stby);
    host.rd(REG_MAX, rv, ack);
    chk("por max", 0, rv);
    results();
  end
endmodule : ledbl_ctrl_tb_top
`default_nettype wire
